/* File: bfsf_pkg.sv */
// Purpose: Shared constants, frame layout and carrier types for the bus fault stack frame unit
// Assumes: 16-bit stack words, 32-bit addresses, Avalon-MM register access with byte addresses
// Notes: Frame word indices count 16-bit words upward from the frame base (lowest address)

package bfsf_pkg;

  // ==========================================================================
  // Frame geometry
  localparam int FRAME_WORDS = 12;
  typedef logic [3:0] bfsf_idx_t;

  localparam bfsf_idx_t W_SR = 4'h0;
  localparam bfsf_idx_t W_PC_HI = 4'h1;
  localparam bfsf_idx_t W_PC_LO = 4'h2;
  localparam bfsf_idx_t W_FMT = 4'h3;
  localparam bfsf_idx_t W_FA_HI = 4'h4;
  localparam bfsf_idx_t W_FA_LO = 4'h5;
  localparam bfsf_idx_t W_DB_HI = 4'h6;
  localparam bfsf_idx_t W_DB_LO = 4'h7;
  localparam bfsf_idx_t W_IPC_HI = 4'h8;
  localparam bfsf_idx_t W_IPC_LO = 4'h9;
  localparam bfsf_idx_t W_TC = 4'ha;
  localparam bfsf_idx_t W_SSW = 4'hb;
  // Exception-processing fault: faulted frame contents reuse the buffer words
  localparam bfsf_idx_t W_XSR = 4'h6;
  localparam bfsf_idx_t W_XFMT = 4'h7;
  // Faulted four-word frame has no faulted PC, so the tail moves down
  localparam bfsf_idx_t W_TC_SHORT = 4'h8;
  localparam bfsf_idx_t W_SSW_SHORT = 4'h9;

  localparam logic [31:0] BYTES_FOUR = 32'h0000_0008;
  localparam logic [31:0] BYTES_SIX = 32'h0000_000c;
  localparam logic [31:0] BYTES_BUS = 32'h0000_0018;
  localparam logic [31:0] BYTES_BUS_SHORT = 32'h0000_0014;
  localparam logic [31:0] TYPE4_GAP = 32'h0000_0006;

  // ==========================================================================
  // Status word layout
  localparam int SSW_TP = 15;
  localparam int SSW_MV = 14;
  localparam int SSW_SIZE_CODE_HIGH = 13;
  localparam int SSW_TR = 12;
  localparam int SSW_B1 = 11;
  localparam int SSW_B0 = 10;
  localparam int SSW_RR = 9;
  localparam int SSW_RM = 8;
  localparam int SSW_IN = 7;
  localparam int SSW_RW = 6;
  localparam int SSW_SIZE_CODE_LOW = 5;
  localparam int SSW_SIZ_HI = 4;
  localparam int SSW_SIZ_LO = 3;
  localparam int SSW_SPACE_CODE_HI = 2;
  localparam int SSW_SPACE_CODE_LO = 0;

  localparam logic [1:0] TYPE_NORMAL = 2'h0;
  localparam logic [1:0] TYPE_MULTI_REGISTER_MOVE = 2'h1;
  localparam logic [1:0] TYPE_EXC = 2'h2;

  // Arbitrary revision value, not tied to any real part
  localparam logic [7:0] MICROCODE_REV = 8'h01;
  localparam logic [7:0] TC_FULL = 8'h10;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_FRAME_LAST = 8'h2c;
  localparam logic [7:0] A_CTRL = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_REV = 8'h48;
  localparam logic [7:0] A_BASE = 8'h4c;
  localparam int CTRL_RETURN = 0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {EXC_FOUR, EXC_SIX, EXC_BKPT} bfsf_exc_e;
  typedef enum logic [1:0] {FR_NONE, FR_FOUR, FR_SIX, FR_BUS} bfsf_frame_e;
  typedef enum logic [2:0] {ACT_RESUME, ACT_RESTART, ACT_CONTINUE, ACT_REBUILD,
                            ACT_REJECT} bfsf_act_e;

  typedef struct packed {
    bfsf_exc_e kind;
    logic pc_is_cause;
    logic [31:0] next_pc;
    logic [31:0] cause_pc;
    logic [15:0] sr;
    logic [15:0] fmtvec;
    logic [31:0] sp;
  } bfsf_exc_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] lane;
    logic dyn;
    logic rw;
    logic [2:0] space_code;
    logic [1:0] remaining_size;
    logic [1:0] szc;
    logic locked;
    logic prefetch;
    logic in_multi_register_move;
    logic in_exc;
    logic trace_pend;
    logic [1:0] bp_pend;
    logic [4:0] attempted;
    logic [31:0] dbuf;
    logic [31:0] instr_pc;
  } bfsf_fault_s;

  typedef struct packed {
    bfsf_act_e action;
    logic rerun;
    logic rw;
    logic [2:0] space_code;
    logic [1:0] remaining_size;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
    logic [31:0] fault_pc;
    logic [15:0] sr;
    logic [15:0] fmtvec;
    logic [7:0] reload_count;
    logic [7:0] rescan_count;
    logic recompute_ea;
    logic requeue_trace;
    logic [1:0] requeue_bp;
  } bfsf_resume_s;

endpackage

/* File: bfsf_ssw_pack.sv */
// Purpose: Builds the special status word for a bus fault frame
// Assumes: Frame type already chosen by the caller
// Notes: Purely combinational

`timescale 1ns/10ps
module bfsf_ssw_pack (
  input wire bfsf_pkg::bfsf_fault_s fault_i,
  input wire logic [1:0] frame_type_i,
  output logic [15:0] ssw_o
);

  always_comb begin
    ssw_o = '0;
    ssw_o[bfsf_pkg::SSW_TP:bfsf_pkg::SSW_MV] = frame_type_i;
    ssw_o[bfsf_pkg::SSW_SIZE_CODE_HIGH] = fault_i.szc[1];
    ssw_o[bfsf_pkg::SSW_TR] = fault_i.trace_pend;
    ssw_o[bfsf_pkg::SSW_B1] = fault_i.bp_pend[1];
    ssw_o[bfsf_pkg::SSW_B0] = fault_i.bp_pend[0];
    ssw_o[bfsf_pkg::SSW_SIZE_CODE_LOW] = fault_i.szc[0];
    ssw_o[bfsf_pkg::SSW_SIZ_HI:bfsf_pkg::SSW_SIZ_LO] = fault_i.remaining_size;
    ssw_o[bfsf_pkg::SSW_SPACE_CODE_HI:bfsf_pkg::SSW_SPACE_CODE_LO] = fault_i.space_code;
    if (frame_type_i == bfsf_pkg::TYPE_EXC) begin
      // Exception stacking only ever faults on a read of the vector or a stack write
      ssw_o[bfsf_pkg::SSW_RW] = 1'b1;
    end else begin
      ssw_o[bfsf_pkg::SSW_RR] = ~fault_i.rw;
      ssw_o[bfsf_pkg::SSW_RM] = fault_i.locked & (frame_type_i == bfsf_pkg::TYPE_NORMAL);
      ssw_o[bfsf_pkg::SSW_IN] = fault_i.prefetch;
      ssw_o[bfsf_pkg::SSW_RW] = fault_i.rw;
    end
  end

endmodule

/* File: bfsf_unit.sv */
// Purpose: Builds exception and bus fault stack frames and decides how return resumes
// Assumes: Core raises one-cycle requests with stable payload; software edits the frame
// Notes: Frame image held in flops; the core copies it to and from memory
//
// What this block does
// - Four-word frame for interrupts and traps; PC is next or causing address.
// - Six-word frame for instruction traps and trace, holding both PCs.
// - Breakpoint six-word frame stores PC executing when breakpoint was sensed.
// - Bus fault pushes a twelve-word frame, ten for a faulted four-word frame; variants told apart by type bits.
// - Status word packs type, continue, size, pending, rerun, lock, prefetch, direction.
// - Normal execution faults are encoded with type bits 00.
// - Block-move operand faults are encoded with type bits 01.
// - Exception processing faults encode 10 and stack from SP minus six.
// - Transfer-count word: revision in upper byte, transfer count in lower byte.
// - Return checks stacked revision against own before restoring a fault frame.
// - Stacked count ignored unless continue flag set; then reloaded into counter.
// - Stacked count equals sixteen minus transfers attempted during a block move, else zero.
// - Dynamically sized cycle records the upper byte address as fault address.
// - Continue return refetches, keeps address, rescans mask, repeats the transfer.
// - Only the block move continues mid-way; normal faults restart, exception faults rebuild.
// - Cleared continue flag makes the frame a normal fault: restart from start.
// - Completed transfers stay done; restart recomputes the effective address.
// - Vector fetch and stacking faults share frame, differing only in address.
// - Exception fault return fetches handler and rebuilds the original frame.
// - Faulted four-word frame puts count at word 8 and status at word 9.
// - Every faulted write outside exception processing sets the rerun flag.
// - Return inspects only rerun; when set, repeats the write with stacked fields.
// - Block-move operand faults set the continue flag.

`timescale 1ns/10ps
module bfsf_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic exc_req_i,
  input wire bfsf_pkg::bfsf_exc_s exc_i,
  input wire logic bus_fault_i,
  input wire bfsf_pkg::bfsf_fault_s fault_i,
  output logic frame_valid_o,
  output logic [31:0] frame_base_o,
  output logic resume_valid_o,
  output bfsf_pkg::bfsf_resume_s resume_o
);

  // ==========================================================================
  // Avalon slave: one wait cycle, read data registered
  logic ack;
  logic next_ack;
  logic [31:0] next_rdata;
  logic wr_ack;
  logic frame_sel;
  bfsf_pkg::bfsf_idx_t frame_idx;

  logic [15:0] frame [bfsf_pkg::FRAME_WORDS];
  logic [15:0] next_frame [bfsf_pkg::FRAME_WORDS];
  bfsf_pkg::bfsf_frame_e st;
  bfsf_pkg::bfsf_frame_e next_st;
  logic short_tail;
  logic next_short_tail;
  logic [31:0] next_base;
  bfsf_pkg::bfsf_act_e last_act;
  bfsf_pkg::bfsf_act_e next_last_act;

  assign frame_sel = (avs_address_i <= bfsf_pkg::A_FRAME_LAST) && (avs_address_i[1:0] == 2'h0);
  assign frame_idx = avs_address_i[5:2];
  assign wr_ack = avs_write_i & ack;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign frame_valid_o = (st != bfsf_pkg::FR_NONE);

  always_comb begin
    next_ack = (avs_read_i | avs_write_i) & ~ack;
    next_rdata = avs_readdata_o;
    if (avs_read_i & ~ack) begin
      next_rdata = '0;
      if (frame_sel) begin
        next_rdata = {16'h0000, frame[frame_idx]};
      end else if (avs_address_i == bfsf_pkg::A_STATUS) begin
        next_rdata = {27'h000_0000, last_act, st};
      end else if (avs_address_i == bfsf_pkg::A_REV) begin
        next_rdata = {24'h00_0000, bfsf_pkg::MICROCODE_REV};
      end else if (avs_address_i == bfsf_pkg::A_BASE) begin
        next_rdata = frame_base_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      ack <= next_ack;
      avs_readdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Frame capture
  logic [1:0] bus_type;
  logic [15:0] ssw_new;
  logic [31:0] fault_addr;
  logic [7:0] tc_low;
  logic ret_go;

  always_comb begin
    if (fault_i.in_exc) begin
      bus_type = bfsf_pkg::TYPE_EXC;
    end else if (fault_i.in_multi_register_move) begin
      bus_type = bfsf_pkg::TYPE_MULTI_REGISTER_MOVE;
    end else begin
      bus_type = bfsf_pkg::TYPE_NORMAL;
    end
  end

  bfsf_ssw_pack u_ssw (
    .fault_i(fault_i),
    .frame_type_i(bus_type),
    .ssw_o(ssw_new)
  );

  // Upper byte of a dynamically sized cycle is the lowest address of the operand
  assign fault_addr = fault_i.dyn ? (fault_i.addr - {30'h0000_0000, fault_i.lane})
                                  : fault_i.addr;
  assign tc_low = fault_i.in_multi_register_move ? (bfsf_pkg::TC_FULL - {3'h0, fault_i.attempted})
                                   : 8'h00;

  always_comb begin
    next_frame = frame;
    next_st = st;
    next_short_tail = short_tail;
    next_base = frame_base_o;
    if (bus_fault_i) begin
      next_st = bfsf_pkg::FR_BUS;
      next_short_tail = 1'b0;
      next_frame[bfsf_pkg::W_SR] = exc_i.sr;
      next_frame[bfsf_pkg::W_PC_HI] = exc_i.next_pc[31:16];
      next_frame[bfsf_pkg::W_PC_LO] = exc_i.next_pc[15:0];
      next_frame[bfsf_pkg::W_FMT] = exc_i.fmtvec;
      // Vector fetch and stacking faults differ only in the address recorded here
      next_frame[bfsf_pkg::W_FA_HI] = fault_addr[31:16];
      next_frame[bfsf_pkg::W_FA_LO] = fault_addr[15:0];
      next_frame[bfsf_pkg::W_DB_HI] = fault_i.dbuf[31:16];
      next_frame[bfsf_pkg::W_DB_LO] = fault_i.dbuf[15:0];
      next_frame[bfsf_pkg::W_IPC_HI] = fault_i.instr_pc[31:16];
      next_frame[bfsf_pkg::W_IPC_LO] = fault_i.instr_pc[15:0];
      next_frame[bfsf_pkg::W_TC] = {bfsf_pkg::MICROCODE_REV, tc_low};
      next_frame[bfsf_pkg::W_SSW] = ssw_new;
      next_base = exc_i.sp - bfsf_pkg::BYTES_BUS;
      if (fault_i.in_exc) begin
        next_frame[bfsf_pkg::W_XSR] = exc_i.sr;
        next_frame[bfsf_pkg::W_XFMT] = exc_i.fmtvec;
        next_frame[bfsf_pkg::W_IPC_HI] = exc_i.cause_pc[31:16];
        next_frame[bfsf_pkg::W_IPC_LO] = exc_i.cause_pc[15:0];
        next_base = exc_i.sp - bfsf_pkg::TYPE4_GAP - bfsf_pkg::BYTES_BUS;
        if (exc_i.kind == bfsf_pkg::EXC_FOUR) begin
          next_short_tail = 1'b1;
          next_frame[bfsf_pkg::W_TC_SHORT] = {bfsf_pkg::MICROCODE_REV, tc_low};
          next_frame[bfsf_pkg::W_SSW_SHORT] = ssw_new;
          next_frame[bfsf_pkg::W_TC] = 16'h0000;
          next_frame[bfsf_pkg::W_SSW] = 16'h0000;
          next_base = exc_i.sp - bfsf_pkg::TYPE4_GAP - bfsf_pkg::BYTES_BUS_SHORT;
        end
      end
    end else if (exc_req_i) begin
      next_short_tail = 1'b0;
      next_frame[bfsf_pkg::W_SR] = exc_i.sr;
      next_frame[bfsf_pkg::W_FMT] = exc_i.fmtvec;
      next_frame[bfsf_pkg::W_PC_HI] = exc_i.next_pc[31:16];
      next_frame[bfsf_pkg::W_PC_LO] = exc_i.next_pc[15:0];
      if (exc_i.kind == bfsf_pkg::EXC_FOUR) begin
        next_st = bfsf_pkg::FR_FOUR;
        next_base = exc_i.sp - bfsf_pkg::BYTES_FOUR;
        if (exc_i.pc_is_cause) begin
          next_frame[bfsf_pkg::W_PC_HI] = exc_i.cause_pc[31:16];
          next_frame[bfsf_pkg::W_PC_LO] = exc_i.cause_pc[15:0];
        end
      end else begin
        // For a breakpoint the core hands over the PC executing when it was sensed
        next_st = bfsf_pkg::FR_SIX;
        next_base = exc_i.sp - bfsf_pkg::BYTES_SIX;
        next_frame[bfsf_pkg::W_FA_HI] = exc_i.cause_pc[31:16];
        next_frame[bfsf_pkg::W_FA_LO] = exc_i.cause_pc[15:0];
      end
    end else if (wr_ack & frame_sel) begin
      // Core events win; a software edit in the same cycle is dropped
      if (avs_byteenable_i[0]) begin
        next_frame[frame_idx][7:0] = avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        next_frame[frame_idx][15:8] = avs_writedata_i[15:8];
      end
    end else if (ret_go && (next_last_act != bfsf_pkg::ACT_REJECT)) begin
      next_st = bfsf_pkg::FR_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame <= '{default: 16'h0000};
      st <= bfsf_pkg::FR_NONE;
      short_tail <= 1'b0;
      frame_base_o <= '0;
    end else begin
      frame <= next_frame;
      st <= next_st;
      short_tail <= next_short_tail;
      frame_base_o <= next_base;
    end
  end

  // ==========================================================================
  // Return from exception
  bfsf_pkg::bfsf_resume_s next_resume;
  logic next_resume_valid;
  logic [15:0] tc_word;
  logic [15:0] ssw_word;

  assign ret_go = wr_ack && (avs_address_i == bfsf_pkg::A_CTRL) && avs_byteenable_i[0]
                  && avs_writedata_i[bfsf_pkg::CTRL_RETURN] && !bus_fault_i && !exc_req_i
                  && (st != bfsf_pkg::FR_NONE);
  assign tc_word = short_tail ? frame[bfsf_pkg::W_TC_SHORT] : frame[bfsf_pkg::W_TC];
  assign ssw_word = short_tail ? frame[bfsf_pkg::W_SSW_SHORT] : frame[bfsf_pkg::W_SSW];

  always_comb begin
    next_resume = '0;
    next_resume.action = bfsf_pkg::ACT_RESUME;
    next_resume.pc = {frame[bfsf_pkg::W_PC_HI], frame[bfsf_pkg::W_PC_LO]};
    next_resume.sr = frame[bfsf_pkg::W_SR];
    next_resume.fmtvec = frame[bfsf_pkg::W_FMT];
    unique case (st)
      bfsf_pkg::FR_NONE: begin
        next_resume.action = bfsf_pkg::ACT_REJECT;
      end
      bfsf_pkg::FR_FOUR, bfsf_pkg::FR_SIX: begin
        next_resume.action = bfsf_pkg::ACT_RESUME;
      end
      bfsf_pkg::FR_BUS: begin
        next_resume.requeue_trace = ssw_word[bfsf_pkg::SSW_TR];
        next_resume.requeue_bp = {ssw_word[bfsf_pkg::SSW_B1], ssw_word[bfsf_pkg::SSW_B0]};
        next_resume.addr = {frame[bfsf_pkg::W_FA_HI], frame[bfsf_pkg::W_FA_LO]};
        next_resume.fault_pc = {frame[bfsf_pkg::W_IPC_HI], frame[bfsf_pkg::W_IPC_LO]};
        // Only the rerun flag decides; edited direction or space bits are taken as found
        if (ssw_word[bfsf_pkg::SSW_RR]) begin
          next_resume.rerun = 1'b1;
          next_resume.rw = ssw_word[bfsf_pkg::SSW_RW];
          next_resume.space_code = ssw_word[bfsf_pkg::SSW_SPACE_CODE_HI:bfsf_pkg::SSW_SPACE_CODE_LO];
          next_resume.remaining_size = ssw_word[bfsf_pkg::SSW_SIZ_HI:bfsf_pkg::SSW_SIZ_LO];
          next_resume.data = {frame[bfsf_pkg::W_DB_HI], frame[bfsf_pkg::W_DB_LO]};
        end
        unique case (ssw_word[bfsf_pkg::SSW_TP:bfsf_pkg::SSW_MV])
          bfsf_pkg::TYPE_MULTI_REGISTER_MOVE: begin
            next_resume.action = bfsf_pkg::ACT_CONTINUE;
            next_resume.reload_count = tc_word[7:0];
            next_resume.rescan_count = bfsf_pkg::TC_FULL - tc_word[7:0];
            next_resume.recompute_ea = 1'b0;
          end
          bfsf_pkg::TYPE_NORMAL: begin
            // Done transfers are not undone and the address is worked out again
            next_resume.action = bfsf_pkg::ACT_RESTART;
            next_resume.recompute_ea = 1'b1;
          end
          bfsf_pkg::TYPE_EXC: begin
            next_resume.action = bfsf_pkg::ACT_REBUILD;
            next_resume.sr = frame[bfsf_pkg::W_XSR];
            next_resume.fmtvec = frame[bfsf_pkg::W_XFMT];
            if (short_tail) begin
              next_resume.fault_pc = '0;
            end
          end
          default: begin
            next_resume.action = bfsf_pkg::ACT_REJECT;
          end
        endcase
        // A frame from another revision cannot be trusted to restore
        if (tc_word[15:8] != bfsf_pkg::MICROCODE_REV) begin
          next_resume.action = bfsf_pkg::ACT_REJECT;
          next_resume.rerun = 1'b0;
          next_resume.reload_count = '0;
          next_resume.rescan_count = '0;
        end
      end
    endcase
    next_resume_valid = ret_go;
    next_last_act = ret_go ? next_resume.action : last_act;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_o <= '0;
      resume_valid_o <= 1'b0;
      last_act <= bfsf_pkg::ACT_RESUME;
    end else begin
      resume_valid_o <= next_resume_valid;
      last_act <= next_last_act;
      if (ret_go) begin
        resume_o <= next_resume;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_multi_register_move_fault;
    bus_fault_i && fault_i.in_multi_register_move && !fault_i.in_exc;
  endsequence

  sequence s_bus_return;
    ret_go && (st == bfsf_pkg::FR_BUS);
  endsequence

  AST_TC_COUNT: assert property (s_multi_register_move_fault |=>
    frame[bfsf_pkg::W_TC][7:0] == (8'h10 - {3'h0, $past(fault_i.attempted)}))
    else $error("stacked transfer count wrong");
  AST_REV_STACKED: assert property (bus_fault_i |=> tc_word[15:8] == 8'h01)
    else $error("revision byte not stacked");
  AST_MULTI_REGISTER_MOVE_TYPE: assert property (s_multi_register_move_fault |=>
    ssw_word[15:14] == 2'h1 && st == bfsf_pkg::FR_BUS)
    else $error("block move fault type wrong");
  AST_NORMAL_TYPE: assert property (bus_fault_i && !fault_i.in_multi_register_move && !fault_i.in_exc
    |=> ssw_word[15:14] == 2'h0)
    else $error("normal fault type wrong");
  AST_EXC_BASE: assert property (bus_fault_i && fault_i.in_exc && exc_i.kind !=
    bfsf_pkg::EXC_FOUR |=> ssw_word[15:14] == 2'h2 &&
    frame_base_o == $past(exc_i.sp) - 32'h0000_001e)
    else $error("exception fault frame misplaced");
  AST_RERUN_WRITE: assert property (bus_fault_i && !fault_i.rw && !fault_i.in_exc
    |=> ssw_word[9])
    else $error("write fault without rerun");
  AST_DYN_ADDR: assert property (bus_fault_i && fault_i.dyn |=>
    {frame[4], frame[5]} == $past(fault_i.addr) - {30'h0000_0000, $past(fault_i.lane)})
    else $error("dynamic fault address not upper byte");
  AST_REV_REJECT: assert property ((s_bus_return and (tc_word[15:8] != 8'h01)) |=>
    resume_valid_o && resume_o.action == bfsf_pkg::ACT_REJECT && st == bfsf_pkg::FR_BUS)
    else $error("foreign revision frame restored");
  AST_COUNT_IGNORED: assert property ((s_bus_return and (ssw_word[15:14] != 2'h1)) |=>
    resume_valid_o && resume_o.reload_count == 8'h00)
    else $error("count used without continue");
  AST_CONTINUE: assert property ((s_bus_return and (ssw_word[15:14] == 2'h1 &&
    tc_word[15:8] == 8'h01)) |=> resume_o.action == bfsf_pkg::ACT_CONTINUE &&
    !resume_o.recompute_ea && resume_o.reload_count == $past(tc_word[7:0]))
    else $error("continue return wrong");
  AST_SHORT_TAIL: assert property (bus_fault_i && fault_i.in_exc &&
    exc_i.kind == bfsf_pkg::EXC_FOUR |=> short_tail && frame[9][15:14] == 2'h2)
    else $error("short frame tail misplaced");

endmodule

/* File: bfsf_unit_test.sv */
// Purpose: Self-checking bench for the bus fault stack frame unit
// Assumes: One core event at a time; register access only between events
// Notes: Random frames from a fixed seed, plus a full-count move and a revision clash
`timescale 1ns/10ps
module bfsf_unit_test;
  logic clk_i, rst_i, avs_read_i, avs_write_i, exc_req_i, bus_fault_i;
  logic avs_waitrequest_o, frame_valid_o, resume_valid_o;
  logic [7:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, frame_base_o, q;
  logic [191:0] r;
  logic [15:0] h, s;
  logic [7:0] cnt, sa, ca;
  logic [1:0] k;
  bfsf_pkg::bfsf_exc_s exc_i, e;
  bfsf_pkg::bfsf_fault_s fault_i, f;
  bfsf_pkg::bfsf_resume_s resume_o;
  int failures, checks_done, seed;

  bfsf_unit u_bfsf_unit (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .exc_req_i(exc_req_i), .exc_i(exc_i),
    .bus_fault_i(bus_fault_i), .fault_i(fault_i), .frame_valid_o(frame_valid_o),
    .frame_base_o(frame_base_o), .resume_valid_o(resume_valid_o), .resume_o(resume_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Request held until the rising edge that sees waitrequest low; data taken at that edge
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      chk(32'h1, 32'h0, "bus timeout");
      end_of_test();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic ev(input logic bf);
    @(posedge clk_i);
    bus_fault_i <= bf;
    exc_req_i <= ~bf;
    fault_i <= f;
    exc_i <= e;
    @(posedge clk_i);
    bus_fault_i <= 1'b0;
    exc_req_i <= 1'b0;
  endtask

  task automatic ret(input bfsf_pkg::bfsf_act_e a);
    av(1'b1, bfsf_pkg::A_CTRL, 32'h0000_0001);
    @(negedge clk_i);
    chk(resume_valid_o, 32'h1, "resume pulse");
    chk(resume_o.action, a, "action");
  endtask

  function automatic logic [15:0] ssw_of(bfsf_pkg::bfsf_fault_s x, logic [1:0] ty);
    return {ty, x.szc[1], x.trace_pend, x.bp_pend, ~x.rw, x.locked, x.prefetch, x.rw,
            x.szc[0], x.remaining_size, x.space_code};
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'ha29b_06d6;
    {rst_i, avs_read_i, avs_write_i, exc_req_i, bus_fault_i} = 5'h10;
    {avs_address_i, avs_writedata_i, exc_i, fault_i, e, f} = '0;
    avs_byteenable_i = 4'hf;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    av(1'b0, bfsf_pkg::A_REV, 32'h0);
    chk(q, {24'h0, bfsf_pkg::MICROCODE_REV}, "revision");
    av(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0, "unmapped read");
    for (int i = 0; i < 12; i++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
           $random(seed)};
      e = r[191:61];
      f = r[118:0];
      // The last exception fault hits a four-word frame, so its tail sits two words lower
      e.kind = (i < 3) ? bfsf_pkg::bfsf_exc_e'(i) :
               (i == 11) ? bfsf_pkg::EXC_FOUR : bfsf_pkg::EXC_SIX;
      e.sp[0] = 1'b0;
      k = 2'(i % 3);
      if (i < 3) begin
        ev(1'b0);
        av(1'b0, bfsf_pkg::A_STATUS, 32'h0);
        chk(q[1:0], (i == 0) ? 32'h1 : 32'h2, "frame size");
        ret(bfsf_pkg::ACT_RESUME);
      end else begin
        f.in_multi_register_move = (k == 2'h1);
        f.in_exc = (k == 2'h2);
        f.attempted = (i == 4) ? 5'h10 : 5'(r[123:120]) + 5'h01;
        if (i == 3) {f.dyn, f.lane} = 3'h7;
        if (k != 2'h0) {f.locked, f.prefetch} = 2'h0;
        if (k == 2'h2) f.rw = 1'b1;
        cnt = f.in_multi_register_move ? 8'h10 - 8'(f.attempted) : 8'h00;
        sa = (i == 11) ? 8'h24 : bfsf_pkg::A_FRAME_LAST;
        ca = (i == 11) ? 8'h20 : 8'h28;
        ev(1'b1);
        @(negedge clk_i);
        chk(frame_valid_o, 32'h1, "frame held");
        av(1'b0, sa, 32'h0);
        s = ssw_of(f, {k[1], k[0]});
        chk(q, {16'h0, s}, "status word");
        av(1'b0, ca, 32'h0);
        chk(q, {16'h0, bfsf_pkg::MICROCODE_REV, cnt}, "count word");
        av(1'b0, 8'h10, 32'h0);
        h = q[15:0];
        av(1'b0, 8'h14, 32'h0);
        chk({h, q[15:0]}, f.dyn ? f.addr - 32'(f.lane) : f.addr, "fault addr");
        if (k == 2'h2) chk(frame_base_o, e.sp - ((i == 11) ? 32'd26 : 32'd30), "base");
        if (i == 4) begin
          // Foreign revision must be refused and leave the frame in place
          av(1'b1, 8'h28, {16'h0, ~bfsf_pkg::MICROCODE_REV, cnt});
          ret(bfsf_pkg::ACT_REJECT);
          chk(frame_valid_o, 32'h1, "kept");
          av(1'b1, 8'h28, {16'h0, bfsf_pkg::MICROCODE_REV, cnt});
        end
        if (i == 7) av(1'b1, bfsf_pkg::A_FRAME_LAST, {16'h0, s & 16'hbfff});
        if (k == 2'h1 && i != 7) begin
          ret(bfsf_pkg::ACT_CONTINUE);
          chk(resume_o.reload_count, cnt, "reload");
          chk(resume_o.recompute_ea, 32'h0, "keep address");
          chk(resume_o.rescan_count, {27'h0, f.attempted}, "rescan");
        end else begin
          ret(k == 2'h2 ? bfsf_pkg::ACT_REBUILD : bfsf_pkg::ACT_RESTART);
          chk(resume_o.recompute_ea, {31'h0, k != 2'h2}, "recompute");
        end
        chk(resume_o.rerun, {31'h0, ~f.rw}, "rerun");
      end
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule
